/* File: core/artc_timer.sv */
// Purpose: 16-bit auto-reload timer with split and capture modes
// Assumes: Avalon-MM slave, word addressing, one wait state
// Notes: Overflow flags stay set until software clears them
// What this block does
// [RL1] Two counter bytes form one 16-bit or two 8-bit auto-reload counters.
// [RL2] Counter clock: system clock, system clock/12, or external clock/8.
// [RL3] External clock/8 tick is synchronised to the system clock first.
// [RL4] 16-bit wrap from 0xFFFF loads reload value and sets high flag.
// [RL5] 16-bit mode: interrupt on every overflow when interrupt enabled.
// [RL6] 16-bit mode: low byte wrap also interrupts when low enable set.
// [RL7] Split mode: each byte reloads from its own reload byte.
// [RL8] Split mode: run bit gates only the high byte; low always counts.
// [RL9] Byte select 1 picks system clock; 0 defers to external select.
// [RL10] Split mode: each byte wrap sets its own overflow flag.
// [RL11] Split mode: high wrap interrupts; low wrap too if low enabled.
// [RL12] Overflow flags are cleared only by software, never hardware.
// [RL13] Software reads both flags to find the interrupt source.
// [RL14] Capture mode counts with system clock or its /12 per selects.
// [RL15] Capture copies the 16-bit count into reloads, sets high flag.
// [RL16] Capture happens on each falling edge of external clock/8.
// [RL17] Software should keep 16-bit mode while capturing.
// [RL18] Software should choose a counter clock much faster than capture.
// [RL19] Capture mode follows the capture-enable bit.
// [RL20] Counter advances only with run bit; split mode: high byte only.
// [RL21] Reset clears counters, reloads and control bits: stopped, 16-bit.
`timescale 1ns/1ps
`include "artc_params.svh"

module artc_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic extOsc,
  output logic irqRequest,
  output logic highOverflowFlag,
  output logic lowOverflowFlag
);

  artc_pkg::artc_ctrl_t ctrl_reg;
  artc_pkg::artc_clkctl_t clkCtl_reg;
  artc_pkg::artc_ticks_t ticks;
  logic [7:0] countLow_reg;
  logic [7:0] countHigh_reg;
  logic [7:0] reloadLow_reg;
  logic [7:0] reloadHigh_reg;
  logic [7:0] countLow_next;
  logic [7:0] countHigh_next;
  logic lowWrap;
  logic highWrap;
  logic lowTick;
  logic highTick;
  logic captureHit;
  logic busWrite;
  logic [7:0] wByte;
  logic lowExtSel;
  logic [1:0] byteSel;
  logic [1:0] byteExt;
  wire logic [1:0] byteTick;
  logic highSet;
  logic lowSet;
  logic accept;
  logic wrCtrl;
  logic wrReloadLow;
  logic wrReloadHigh;
  logic wrCountLow;
  logic wrCountHigh;
  logic wrClkCtl;

  artc_clk_src artc_clk_src_inst (
    .mclk(mclk),
    .rst(rst),
    .extOsc(extOsc),
    .ticks(ticks)
  );

  // Per-byte clock choice
  function automatic logic pickTick(
    input logic byteSel,
    input logic extSel,
    input artc_pkg::artc_ticks_t t
  );
    if (byteSel) begin
      pickTick = 1'b1; // [RL9]
    end else if (extSel) begin
      pickTick = t.ext8Tick; // [RL9]
    end else begin
      pickTick = t.div12Tick; // [RL9]
    end
  endfunction

  function automatic logic writesTo(input logic [2:0] idx,
                                    input logic doWrite,
                                    input logic [2:0] addr);
    writesTo = doWrite && (addr == idx);
  endfunction

  // Capture mode never counts the low byte on the clock it measures
  always_comb begin
    lowExtSel = ctrl_reg.externalClockSelect;
    if (ctrl_reg.captureEnable) begin
      lowExtSel = 1'b0; // [RL14]
    end
  end

  assign byteSel = {clkCtl_reg.highByteClockSelect,
    clkCtl_reg.lowByteClockSelect};
  assign byteExt = {ctrl_reg.externalClockSelect, lowExtSel};

  // One tick selector per counter byte
  for (genvar b = 0; b < 2; b++) begin : g_tick
    assign byteTick[b] = pickTick(byteSel[b], byteExt[b], ticks); // [RL9]
  end

  // Low select also drives 16-bit and capture operation
  assign lowTick = byteTick[0]; // [RL2] [RL14]
  assign highTick = byteTick[1]; // [RL2]
  assign captureHit = ctrl_reg.captureEnable &&
    ticks.captureEvent; // [RL19] [RL16]

  // Bus write takes effect at the edge where waitrequest is low
  assign busWrite = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wByte = avs_writedata[7:0];
  assign accept = (avs_read || avs_write) && avs_waitrequest;

  // Write strobes, one per register
  assign wrCtrl = writesTo(`ARTC_IDX_CTRL, busWrite, avs_address);
  assign wrReloadLow = writesTo(`ARTC_IDX_RELOAD_LOW, busWrite,
    avs_address);
  assign wrReloadHigh = writesTo(`ARTC_IDX_RELOAD_HIGH, busWrite,
    avs_address);
  assign wrCountLow = writesTo(`ARTC_IDX_COUNT_LOW, busWrite,
    avs_address);
  assign wrCountHigh = writesTo(`ARTC_IDX_COUNT_HIGH, busWrite,
    avs_address);
  assign wrClkCtl = writesTo(`ARTC_IDX_CLKCTL, busWrite, avs_address);

  // Hardware events that set the sticky flags
  assign highSet = highWrap || captureHit; // [RL4] [RL10] [RL15]
  assign lowSet = lowWrap; // [RL10]

  always_comb begin
    countLow_next = countLow_reg;
    countHigh_next = countHigh_reg;
    lowWrap = 1'b0;
    highWrap = 1'b0;
    if (ctrl_reg.splitModeSelect) begin // [RL1]
      if (lowTick) begin // [RL8]
        if (countLow_reg == `ARTC_BYTE_MAX) begin
          lowWrap = 1'b1;
          countLow_next = reloadLow_reg; // [RL7]
        end else begin
          countLow_next = countLow_reg + 8'h01;
        end
      end
      if (ctrl_reg.runControl && highTick) begin // [RL8] [RL20]
        if (countHigh_reg == `ARTC_BYTE_MAX) begin
          highWrap = 1'b1;
          countHigh_next = reloadHigh_reg; // [RL7]
        end else begin
          countHigh_next = countHigh_reg + 8'h01;
        end
      end
    end else if (ctrl_reg.runControl && lowTick) begin // [RL20]
      if (countLow_reg == `ARTC_BYTE_MAX) begin
        lowWrap = 1'b1;
        if (countHigh_reg == `ARTC_BYTE_MAX) begin
          highWrap = 1'b1;
          countLow_next = reloadLow_reg; // [RL4]
          countHigh_next = reloadHigh_reg; // [RL4]
        end else begin
          countLow_next = `ARTC_BYTE_RESET;
          countHigh_next = countHigh_reg + 8'h01; // [RL1]
        end
      end else begin
        countLow_next = countLow_reg + 8'h01;
      end
    end
  end

  // Counter bytes; a bus write overrides counting
  always_ff @(posedge mclk) begin
    if (rst) begin
      countLow_reg <= `ARTC_BYTE_RESET; // [RL21]
    end else if (wrCountLow) begin
      countLow_reg <= wByte;
    end else begin
      countLow_reg <= countLow_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      countHigh_reg <= `ARTC_BYTE_RESET; // [RL21]
    end else if (wrCountHigh) begin
      countHigh_reg <= wByte;
    end else begin
      countHigh_reg <= countHigh_next;
    end
  end

  // Reload bytes; capture wins over a bus write
  always_ff @(posedge mclk) begin
    if (rst) begin
      reloadLow_reg <= `ARTC_BYTE_RESET; // [RL21]
      reloadHigh_reg <= `ARTC_BYTE_RESET; // [RL21]
    end else if (captureHit) begin
      reloadLow_reg <= countLow_reg; // [RL15]
      reloadHigh_reg <= countHigh_reg; // [RL15]
    end else begin
      if (wrReloadLow) begin
        reloadLow_reg <= wByte;
      end
      if (wrReloadHigh) begin
        reloadHigh_reg <= wByte;
      end
    end
  end

  // Control bits; hardware set wins over software clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= '0; // [RL21]
    end else begin
      if (wrCtrl) begin
        ctrl_reg <= wByte;
        ctrl_reg.unusedBit <= 1'b0;
        ctrl_reg.highOverflowFlag <= wByte[`ARTC_BIT_HIGH_OVF] |
          highSet; // [RL12]
        ctrl_reg.lowOverflowFlag <= wByte[`ARTC_BIT_LOW_OVF] |
          lowSet; // [RL12]
      end else begin
        if (highSet) begin
          ctrl_reg.highOverflowFlag <= 1'b1; // [RL4] [RL10] [RL15]
        end
        if (lowSet) begin
          ctrl_reg.lowOverflowFlag <= 1'b1; // [RL10]
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clkCtl_reg <= '0; // [RL21]
    end else if (wrClkCtl) begin
      clkCtl_reg <= wByte;
      clkCtl_reg.reserved <= 5'h00;
    end
  end

  // Interrupt request follows the flags; flags only cleared by software
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= clkCtl_reg.irqEnable &&
        (ctrl_reg.highOverflowFlag || // [RL5] [RL11]
        (ctrl_reg.lowByteIrqEnable &&
        ctrl_reg.lowOverflowFlag)); // [RL6] [RL11]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      highOverflowFlag <= 1'b0;
      lowOverflowFlag <= 1'b0;
    end else begin
      highOverflowFlag <= ctrl_reg.highOverflowFlag;
      lowOverflowFlag <= ctrl_reg.lowOverflowFlag;
    end
  end

  // Read multiplexer; unmapped words read zero
  function automatic logic [31:0] readMux(input logic [2:0] addr);
    case (addr)
      `ARTC_IDX_CTRL: readMux = {24'h000000, ctrl_reg};
      `ARTC_IDX_RELOAD_LOW: readMux = {24'h000000, reloadLow_reg};
      `ARTC_IDX_RELOAD_HIGH: readMux = {24'h000000, reloadHigh_reg};
      `ARTC_IDX_COUNT_LOW: readMux = {24'h000000, countLow_reg};
      `ARTC_IDX_COUNT_HIGH: readMux = {24'h000000, countHigh_reg};
      `ARTC_IDX_CLKCTL: readMux = {24'h000000, clkCtl_reg};
      default: readMux = `ARTC_WORD_ZERO;
    endcase
  endfunction

  // One wait state: waitrequest drops for one cycle per request
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !accept;
    end
  end

  // Read data stands until the next request is accepted
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= `ARTC_WORD_ZERO;
    end else if (accept) begin
      avs_readdata <= avs_read ? readMux(avs_address) : `ARTC_WORD_ZERO;
    end
  end

endmodule

/* File: core/artc_params.svh */
// Purpose: Constants for the auto-reload timer with capture
// Assumes: Word-indexed register map on a 32-bit Avalon-MM slave
// Notes: Byte address of a register is four times its index
`ifndef ARTC_PARAMS_SVH
`define ARTC_PARAMS_SVH

// Register word indices
`define ARTC_IDX_CTRL 3'h0
`define ARTC_IDX_RELOAD_LOW 3'h1
`define ARTC_IDX_RELOAD_HIGH 3'h2
`define ARTC_IDX_COUNT_LOW 3'h3
`define ARTC_IDX_COUNT_HIGH 3'h4
`define ARTC_IDX_CLKCTL 3'h5

// Control register bit positions
`define ARTC_BIT_HIGH_OVF 7
`define ARTC_BIT_LOW_OVF 6
`define ARTC_BIT_LOW_IRQ_EN 5
`define ARTC_BIT_CAPTURE_EN 4
`define ARTC_BIT_SPLIT 3
`define ARTC_BIT_RUN 2
`define ARTC_BIT_UNUSED 1
`define ARTC_BIT_EXT_SEL 0

// Clock control register bit positions
`define ARTC_BIT_HIGH_CLK_SEL 7
`define ARTC_BIT_LOW_CLK_SEL 6
`define ARTC_BIT_IRQ_ENABLE 0

// Reset values and byte limits
`define ARTC_BYTE_RESET 8'h00
`define ARTC_BYTE_MAX 8'hff
`define ARTC_WORD_ZERO 32'h0000_0000

// Divider terminal counts
`define ARTC_DIV12_LAST 4'hb
`define ARTC_EXT_DIV_RISE 3'h3
`define ARTC_EXT_DIV_LAST 3'h7

`endif

/* File: core/artc_pkg.sv */
// Purpose: Types shared by the timer files
// Assumes: Bit layout matches artc_params.svh
// Notes: Nothing here is imported; use artc_pkg::name
package artc_pkg;

  typedef struct packed {
    logic highOverflowFlag;
    logic lowOverflowFlag;
    logic lowByteIrqEnable;
    logic captureEnable;
    logic splitModeSelect;
    logic runControl;
    logic unusedBit;
    logic externalClockSelect;
  } artc_ctrl_t;

  typedef struct packed {
    logic highByteClockSelect;
    logic lowByteClockSelect;
    logic [4:0] reserved;
    logic irqEnable;
  } artc_clkctl_t;

  typedef struct packed {
    logic div12Tick;
    logic ext8Tick;
    logic captureEvent;
  } artc_ticks_t;

endpackage

/* File: core/artc_clk_src.sv */
// Purpose: Tick sources: system clock/12 and external oscillator/8
// Assumes: extOsc is far slower than mclk
// Notes: All ticks are one-cycle enables from flip-flops
`timescale 1ns/1ps
`include "artc_params.svh"

module artc_clk_src (
  input wire logic mclk,
  input wire logic rst,
  input wire logic extOsc,
  output artc_pkg::artc_ticks_t ticks
);

  logic syncFirst_reg;
  logic syncSecond_reg;
  logic syncPrev_reg;
  logic [2:0] extCount_reg;
  logic [3:0] div12Count_reg;
  logic extRise;

  // Two-flop synchroniser, then edge history
  always_ff @(posedge mclk) begin // [RL3]
    if (rst) begin
      syncFirst_reg <= 1'b0;
      syncSecond_reg <= 1'b0;
      syncPrev_reg <= 1'b0;
    end else begin
      syncFirst_reg <= extOsc;
      syncSecond_reg <= syncFirst_reg;
      syncPrev_reg <= syncSecond_reg;
    end
  end

  assign extRise = syncSecond_reg & ~syncPrev_reg;

  // Divide by 8; divided clock is extCount_reg[2]
  always_ff @(posedge mclk) begin // [RL2]
    if (rst) begin
      extCount_reg <= 3'h0;
    end else if (extRise) begin
      extCount_reg <= extCount_reg + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin // [RL2]
    if (rst) begin
      div12Count_reg <= 4'h0;
    end else if (div12Count_reg == `ARTC_DIV12_LAST) begin
      div12Count_reg <= 4'h0;
    end else begin
      div12Count_reg <= div12Count_reg + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ticks <= '0;
    end else begin
      ticks.div12Tick <= (div12Count_reg == `ARTC_DIV12_LAST);
      // Rising edge of divided clock advances the counter
      ticks.ext8Tick <= extRise && (extCount_reg == `ARTC_EXT_DIV_RISE);
      // Falling edge of divided clock is the capture event
      ticks.captureEvent <= extRise &&
        (extCount_reg == `ARTC_EXT_DIV_LAST); // [RL16]
    end
  end

endmodule

/* File: testbench/artc_timer_checker.sv */
// Purpose: Port-level assertions for the timer
// Assumes: Enables are tracked from bus writes
// Notes: Bound to every artc_timer instance
`timescale 1ns/1ps
module artc_timer_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic extOsc,
  input wire logic irqRequest,
  input wire logic highOverflowFlag,
  input wire logic lowOverflowFlag
);
  logic wrAny;
  logic wrCtrl;
  logic clrHi;
  logic clrLo;
  logic lowEnReg;
  logic irqEnReg;
  assign wrAny = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wrCtrl = wrAny && avs_address == 3'h0;
  assign clrHi = wrCtrl && !avs_writedata[7];
  assign clrLo = wrCtrl && !avs_writedata[6];
  // Shadows of the two interrupt enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      lowEnReg <= 1'b0;
      irqEnReg <= 1'b0;
    end else begin
      if (wrCtrl) begin
        lowEnReg <= avs_writedata[5];
      end
      if (wrAny && avs_address == 3'h5) begin
        irqEnReg <= avs_writedata[0];
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_swSet;
    wrCtrl && avs_writedata[7];
  endsequence
  property p_rst_quiet;
    disable iff (1'b0) rst && $past(rst) && $past(rst, 2) |->
      !irqRequest && !highOverflowFlag && !lowOverflowFlag && avs_waitrequest;
  endproperty
  property p_hi_sticky;
    $fell(highOverflowFlag) |-> $past(clrHi, 2) || $past(rst) ||
      $past(rst, 2);
  endproperty
  property p_lo_sticky;
    $fell(lowOverflowFlag) |-> $past(clrLo, 2) || $past(rst) ||
      $past(rst, 2);
  endproperty
  property p_sw_set;
    s_swSet |-> ##2 highOverflowFlag;
  endproperty
  property p_irq_cause;
    irqRequest |-> highOverflowFlag || lowOverflowFlag
      || $past(highOverflowFlag) || $past(lowOverflowFlag);
  endproperty
  property p_irq_en;
    irqRequest |-> irqEnReg || $past(irqEnReg);
  endproperty
  property p_irq_low;
    irqRequest && !highOverflowFlag && !$past(highOverflowFlag) |->
      lowEnReg || $past(lowEnReg);
  endproperty
  property p_rd_data;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000
      && (avs_address < 3'h6 || avs_readdata[7:0] == 8'h00);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active in reset");
  a_hi_sticky: assert property (p_hi_sticky)
    else $error("high flag fell without clear");
  a_lo_sticky: assert property (p_lo_sticky)
    else $error("low flag fell without clear");
  a_sw_set: assert property (p_sw_set)
    else $error("high flag not set by write");
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without flag");
  a_irq_en: assert property (p_irq_en)
    else $error("irq while disabled");
  a_irq_low: assert property (p_irq_low)
    else $error("low irq while low enable off");
  a_rd_data: assert property (p_rd_data)
    else $error("read data outside byte");
endmodule

bind artc_timer artc_timer_checker artc_timer_checker_inst (.*);

/* File: testbench/artc_timer_bench.sv */
// Purpose: Directed bench for the auto-reload timer
// Assumes: External oscillator of 8 mclk periods
// Notes: Bus accesses wait on waitrequest
`timescale 1ns/1ps
module artc_timer_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic extOsc = 1'b0;
  logic [1:0] extCnt = 2'h0;
  logic irqRequest;
  logic highOverflowFlag;
  logic lowOverflowFlag;
  logic [31:0] rdq;
  int err_total = 0;
  int tests_run = 0;

  artc_timer artc_timer_inst (.*);

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    extCnt <= extCnt + 2'h1;
    if (extCnt == 2'h3) begin
      extOsc <= ~extOsc;
    end
  end

  task automatic conclude();
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    chk("wait cycles", 32'd2, n);
    rdq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic waitf(input logic hi);
    int n;
    n = 0;
    while ((hi ? highOverflowFlag : lowOverflowFlag) !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, i[2:0], 8'h00);
      chk("reset value", 32'h0, rdq);
    end
  endtask

  task automatic t_wrap16();
    bus(1'b1, 3'h5, 8'h41);
    bus(1'b1, 3'h1, 8'h34);
    bus(1'b1, 3'h2, 8'h12);
    bus(1'b1, 3'h4, 8'hff);
    bus(1'b1, 3'h3, 8'hf0);
    bus(1'b1, 3'h0, 8'h05);
    waitf(1'b1);
    chk("high flag", 32'h1, {31'h0, highOverflowFlag});
    repeat (2) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irqRequest});
    bus(1'b1, 3'h0, 8'hc1);
    bus(1'b0, 3'h4, 8'h00);
    chk("count high", 32'h12, rdq);
    repeat (30) @(posedge mclk);
    chk("flag held", 32'h1, {31'h0, highOverflowFlag});
    bus(1'b1, 3'h0, 8'h00);
    repeat (3) @(posedge mclk);
    chk("flag cleared", 32'h0, {31'h0, highOverflowFlag});
  endtask

  task automatic t_split();
    logic ok;
    bus(1'b1, 3'h5, 8'hc1);
    bus(1'b1, 3'h4, 8'h77);
    bus(1'b1, 3'h3, 8'hf0);
    bus(1'b1, 3'h0, 8'h28);
    waitf(1'b0);
    chk("low flag", 32'h1, {31'h0, lowOverflowFlag});
    repeat (2) @(posedge mclk);
    chk("low irq", 32'h1, {31'h0, irqRequest});
    chk("high flag", 32'h0, {31'h0, highOverflowFlag});
    bus(1'b0, 3'h4, 8'h00);
    chk("split high", 32'h77, rdq);
    bus(1'b0, 3'h3, 8'h00);
    ok = rdq >= 32'h34 && rdq <= 32'h50;
    chk("split reload", 32'h1, {31'h0, ok});
    bus(1'b1, 3'h0, 8'h00);
  endtask

  task automatic t_rate(input logic [7:0] ctl, input int span);
    logic ok;
    bus(1'b1, 3'h5, 8'h00);
    bus(1'b1, 3'h3, 8'h00);
    bus(1'b1, 3'h4, 8'h00);
    bus(1'b1, 3'h0, ctl | 8'h04);
    repeat (span) @(posedge mclk);
    bus(1'b1, 3'h0, ctl & 8'hef);
    bus(1'b0, 3'h3, 8'h00);
    ok = rdq >= 32'h9 && rdq <= 32'hb;
    chk("tick count", 32'h1, {31'h0, ok});
  endtask

  task automatic t_capture();
    logic [15:0] v1;
    logic [15:0] v2;
    bus(1'b1, 3'h5, 8'h40);
    bus(1'b1, 3'h3, 8'h00);
    bus(1'b1, 3'h0, 8'h14);
    waitf(1'b1);
    bus(1'b1, 3'h0, 8'h14);
    bus(1'b0, 3'h1, 8'h00);
    v1[7:0] = rdq[7:0];
    bus(1'b0, 3'h2, 8'h00);
    v1[15:8] = rdq[7:0];
    waitf(1'b1);
    chk("capture flag", 32'h1, {31'h0, highOverflowFlag});
    bus(1'b0, 3'h1, 8'h00);
    v2[7:0] = rdq[7:0];
    bus(1'b0, 3'h2, 8'h00);
    v2[15:8] = rdq[7:0];
    chk("capture span", 32'd64, {16'h0, v2 - v1});
    bus(1'b1, 3'h0, 8'h04);
    bus(1'b1, 3'h0, 8'h04);
    repeat (150) @(posedge mclk);
    chk("capture off", 32'h0, {31'h0, highOverflowFlag});
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_wrap16();
    t_split();
    t_rate(8'h00, 120);
    t_rate(8'h01, 640);
    t_rate(8'h11, 120);
    t_capture();
    conclude();
  end

  initial begin
    #300000;
    err_total++;
    conclude();
  end
endmodule
